// [design/shc_calibration_engine.v]
`timescale 1ns/1ps
`default_nettype none
`include "shc_regs.vh"
// Overview of operation
// - Dark table per single-line or other modes
// - Gain table per single-line or other modes
// - Generate field write starts collecting acquisitions
// - Dark run collects at least 64 lines
// - Line and data valid behave as normal
// - No command acknowledged while collecting
// - Average each pixel over collected lines
// - Brightest averaged pixel is the reference
// - Dark offset raises pixel to reference
// - New table overwrites user nonvolatile area
// - User table activated automatically on completion
// - Gain fully corrects pixels at or above 67 percent
// - Gain run collects 128 lines, gains
// - Gain variants raw or dark-corrected
// - Activation and reset copy table to working
module shc_calibration_engine #(
  parameter LW = 11,
  parameter PW = 8,
  parameter DW = 16
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Host control link.
  input wire cmd_valid,
  input wire csr_wr,
  input wire [1:0] csr_gen,
  input wire single_line_mode,
  output reg cmd_ack,
  output reg gen_busy,
  output reg gen_done,
  // Line trigger pin and its forward to the sensor.
  input wire line_trigger_in,
  output reg sensor_trigger,
  // Sensor pixel stream.
  input wire lv_in,
  input wire dv_in,
  input wire [PW-1:0] pix_in,
  output reg line_valid_out,
  output reg data_valid_out,
  output reg [PW-1:0] pix_out,
  // Nonvolatile storage, read data one cycle after nv_rd_en.
  input wire nv_active_user,
  input wire [DW-1:0] nv_rd_data,
  output reg nv_rd_en,
  output reg nv_wr_en,
  output reg [LW+2:0] nv_addr,
  output reg [DW-1:0] nv_wr_data,
  output reg active_user,
  // Working memory used by the correction datapath.
  output reg work_wr_en,
  output reg [LW+1:0] work_addr,
  output reg [DW-1:0] work_data
);
  localparam AW = PW + 8;
  localparam [LW-1:0] LAST = {LW{1'b1}};
  localparam [6:0] S_INIT = 7'h01;
  localparam [6:0] S_IDLE = 7'h02;
  localparam [6:0] S_ARM = 7'h04;
  localparam [6:0] S_ACC = 7'h08;
  localparam [6:0] S_MAX = 7'h10;
  localparam [6:0] S_CALC = 7'h20;
  localparam [6:0] S_COPY = 7'h40;

  reg [6:0] state;
  reg trig_s1;
  reg trig_s2;
  reg lv_q;
  reg in_line;
  reg [LW:0] pix_idx;
  reg [7:0] line_cnt;
  reg [LW-1:0] idx;
  reg [LW+1:0] cnt;
  reg [1:0] phase;
  reg is_gain;
  reg use_dark;
  reg single;
  reg boot;
  reg [PW-1:0] ref_level;
  wire line_start;
  wire line_end;
  wire acc_en;
  wire [AW-1:0] acc_rd;
  wire [PW-1:0] avg;
  wire [PW-1:0] avg_gain;
  wire [PW-1:0] avg_dark;
  wire [DW-1:0] calc_val;
  wire [7:0] target;

  assign line_start = lv_in & ~lv_q;
  assign line_end = lv_q & ~lv_in;
  assign target = is_gain ? `SHC_GAIN_LINES : `SHC_DARK_LINES;
  // At a line start the index still holds the last line's count, so the
  // first pixel must not be judged by it.
  assign acc_en = (state == S_ACC) && (in_line || line_start) && dv_in &&
                  (line_start || !pix_idx[LW]);
  // Power-of-two line counts make the average a plain shift.
  assign avg_gain = acc_rd[`SHC_GAIN_SHIFT+PW-1:`SHC_GAIN_SHIFT];
  assign avg_dark = acc_rd[`SHC_DARK_SHIFT+PW-1:`SHC_DARK_SHIFT];
  assign avg = is_gain ? avg_gain : avg_dark;

  shc_accum #(
    .LW(LW),
    .PW(PW),
    .AW(AW)
  ) u_accum (
    .core_clk(core_clk),
    .wr_en(acc_en),
    .first(line_cnt == 8'h00),
    .wr_addr(line_start ? {LW{1'b0}} : pix_idx[LW-1:0]),
    .pix(pix_in),
    .rd_addr(idx),
    .rd_data(acc_rd)
  );

  shc_corr_calc #(
    .PW(PW),
    .DW(DW)
  ) u_calc (
    .avg(avg),
    .ref_level(ref_level),
    .dark_off(nv_rd_data),
    .use_dark(use_dark),
    .is_gain(is_gain),
    .value(calc_val)
  );

  // The trigger pin is asynchronous, so only the second stage is used.
  always @(posedge core_clk) begin
    if (!reset_n) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      sensor_trigger <= 1'b0;
    end else begin
      trig_s1 <= line_trigger_in;
      trig_s2 <= trig_s1;
      sensor_trigger <= trig_s2;
    end
  end

  // Calibration lines leave the block exactly like normal lines.
  always @(posedge core_clk) begin
    if (!reset_n) begin
      lv_q <= 1'b0;
      line_valid_out <= 1'b0;
      data_valid_out <= 1'b0;
      pix_out <= {PW{1'b0}};
    end else begin
      lv_q <= lv_in;
      line_valid_out <= lv_in;
      data_valid_out <= dv_in;
      pix_out <= pix_in;
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      state <= S_INIT;
      cmd_ack <= 1'b0;
      gen_busy <= 1'b0;
      gen_done <= 1'b0;
      nv_rd_en <= 1'b0;
      nv_wr_en <= 1'b0;
      nv_addr <= {(LW+3){1'b0}};
      nv_wr_data <= {DW{1'b0}};
      active_user <= 1'b0;
      work_wr_en <= 1'b0;
      work_addr <= {(LW+2){1'b0}};
      work_data <= {DW{1'b0}};
      in_line <= 1'b0;
      pix_idx <= {(LW+1){1'b0}};
      line_cnt <= 8'h00;
      idx <= {LW{1'b0}};
      cnt <= {(LW+2){1'b0}};
      phase <= 2'h0;
      is_gain <= 1'b0;
      use_dark <= 1'b0;
      single <= 1'b0;
      boot <= 1'b0;
      ref_level <= {PW{1'b0}};
    end else begin
      cmd_ack <= 1'b0;
      gen_done <= 1'b0;
      nv_rd_en <= 1'b0;
      nv_wr_en <= 1'b0;
      work_wr_en <= 1'b0;
      // The index saturates so a long line cannot wrap onto slot 0.
      if (dv_in && !pix_idx[LW]) begin
        pix_idx <= pix_idx + 1'b1;
      end
      if (line_start) begin
        pix_idx <= {{LW{1'b0}}, dv_in};
      end
      case (state)
        S_INIT: begin
          // The stored link is caught after release, not under reset.
          active_user <= nv_active_user;
          boot <= 1'b1;
          cnt <= {(LW+2){1'b0}};
          phase <= 2'h0;
          state <= S_COPY;
        end
        S_IDLE: begin
          gen_busy <= 1'b0;
          // After a run the first idle cycle still shows busy; nothing is taken then.
          cmd_ack <= cmd_valid && !gen_busy;
          if (cmd_valid && csr_wr && csr_gen != 2'h0 &&
              !gen_busy) begin
            is_gain <= csr_gen != `SHC_GEN_DARK;
            use_dark <= csr_gen == `SHC_GEN_GAIN_DARK;
            single <= single_line_mode;
            line_cnt <= 8'h00;
            in_line <= 1'b0;
            ref_level <= {PW{1'b0}};
            gen_busy <= 1'b1;
            state <= S_ARM;
          end
        end
        S_ARM: begin
          // A line already running at the start is skipped whole.
          if (!lv_in && !lv_q) begin
            state <= S_ACC;
          end
        end
        S_ACC: begin
          if (line_start) begin
            in_line <= 1'b1;
          end
          if (line_end && in_line) begin
            in_line <= 1'b0;
            line_cnt <= line_cnt + 1'b1;
            if (line_cnt + 1'b1 == target) begin
              idx <= {LW{1'b0}};
              state <= S_MAX;
            end
          end
        end
        S_MAX: begin
          if (avg > ref_level) begin
            ref_level <= avg;
          end
          idx <= idx + 1'b1;
          if (idx == LAST) begin
            phase <= 2'h0;
            state <= S_CALC;
          end
        end
        S_CALC: begin
          phase <= phase + 1'b1;
          if (phase == 2'h0) begin
            // Fetch the stored dark offset for the dark-corrected variant.
            nv_rd_en <= 1'b1;
            nv_addr <= {1'b1, 1'b0, single, idx};
          end else if (phase == 2'h2) begin
            phase <= 2'h0;
            nv_wr_en <= 1'b1;
            nv_addr <= {1'b1, is_gain, single, idx};
            nv_wr_data <= calc_val;
            idx <= idx + 1'b1;
            if (idx == LAST) begin
              active_user <= 1'b1;
              boot <= 1'b0;
              cnt <= {(LW+2){1'b0}};
              state <= S_COPY;
            end
          end
        end
        S_COPY: begin
          phase <= phase + 1'b1;
          if (phase == 2'h0) begin
            nv_rd_en <= 1'b1;
            nv_addr <= {active_user, cnt};
          end else if (phase == 2'h2) begin
            phase <= 2'h0;
            work_wr_en <= 1'b1;
            work_addr <= cnt;
            work_data <= nv_rd_data;
            cnt <= cnt + 1'b1;
            if (&cnt) begin
              gen_done <= !boot;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_INIT;
        end
      endcase
      // Commands stay unanswered for the whole run.
      if (state != S_IDLE) begin
        cmd_ack <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [design/shc_regs.vh]
`ifndef SHC_REGS_VH
`define SHC_REGS_VH
// Acquisitions per run and matching averaging shifts.
`define SHC_DARK_LINES 8'd64
`define SHC_GAIN_LINES 8'd128
`define SHC_DARK_SHIFT 3'd6
`define SHC_GAIN_SHIFT 3'd7
// Generate field values of the calibration start register.
`define SHC_GEN_DARK 2'h1
`define SHC_GEN_GAIN 2'h2
`define SHC_GEN_GAIN_DARK 2'h3
// Fully corrected pixels reach this percentage of the reference.
`define SHC_GAIN_MIN_PCT 7'd67
`define SHC_PCT_FULL 7'd100
// Fraction bits of a gain entry.
`define SHC_GAIN_FRAC 8
`endif

// [design/shc_accum.v]
`timescale 1ns/1ps
`default_nettype none
module shc_accum #(
  parameter LW = 11,
  parameter PW = 8,
  parameter AW = 15
) (
  // Clock.
  input wire core_clk,
  // Accumulate port.
  input wire wr_en,
  input wire first,
  input wire [LW-1:0] wr_addr,
  input wire [PW-1:0] pix,
  // Read port.
  input wire [LW-1:0] rd_addr,
  output wire [AW-1:0] rd_data
);
  reg [AW-1:0] acc [0:(1<<LW)-1];

  // The first line overwrites, so no clearing pass is needed.
  always @(posedge core_clk) begin
    if (wr_en) begin
      if (first) begin
        acc[wr_addr] <= {{(AW-PW){1'b0}}, pix};
      end else begin
        acc[wr_addr] <= acc[wr_addr] + {{(AW-PW){1'b0}}, pix};
      end
    end
  end

  assign rd_data = acc[rd_addr];
endmodule
`default_nettype wire

// [design/shc_corr_calc.v]
`timescale 1ns/1ps
`default_nettype none
`include "shc_regs.vh"
module shc_corr_calc #(
  parameter PW = 8,
  parameter DW = 16
) (
  // Operands.
  input wire [PW-1:0] avg,
  input wire [PW-1:0] ref_level,
  input wire [DW-1:0] dark_off,
  input wire use_dark,
  input wire is_gain,
  // Result.
  output reg [DW-1:0] value
);
  reg [DW:0] corr;
  reg [DW+`SHC_GAIN_FRAC:0] num;
  reg [DW+8:0] lhs;
  reg [DW+8:0] rhs;
  reg [DW+8:0] quo;

  always @* begin
    quo = {(DW+9){1'b0}};
    corr = {{(DW+1-PW){1'b0}}, avg};
    if (use_dark) begin
      corr = corr + {1'b0, dark_off};
    end
    if (corr > {{(DW+1-PW){1'b0}}, ref_level}) begin
      corr = {{(DW+1-PW){1'b0}}, ref_level};
    end
    num = {{(DW+1-PW){1'b0}}, ref_level} << `SHC_GAIN_FRAC;
    lhs = corr * `SHC_PCT_FULL;
    rhs = {{(DW+9-PW){1'b0}}, ref_level} * `SHC_GAIN_MIN_PCT;
    if (!is_gain) begin
      value = {{(DW-PW){1'b0}}, ref_level - avg};
    end else if (corr == {(DW+1){1'b0}} || lhs < rhs) begin
      // Below the limit the gain saturates at the ratio of the limit.
      // A black reference gives zero rather than a divide by zero.
      if (rhs != {(DW+9){1'b0}}) begin
        quo = (num * `SHC_PCT_FULL) / rhs;
      end
      value = quo[DW-1:0];
    end else begin
      quo = num / corr;
      value = quo[DW-1:0];
    end
  end
endmodule
`default_nettype wire

// [sim/shc_cal_props.sv]
`timescale 1ns/1ps
`default_nettype none
module shc_cal_props #(parameter LW = 3) (
  // Control link.
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic csr_wr,
  input wire logic [1:0] csr_gen,
  input wire logic single_line_mode,
  input wire logic cmd_ack,
  input wire logic gen_busy,
  input wire logic gen_done,
  input wire logic active_user,
  // Stream and storage.
  input wire logic lv_in,
  input wire logic dv_in,
  input wire logic line_valid_out,
  input wire logic data_valid_out,
  input wire logic nv_wr_en,
  input wire logic [LW+2:0] nv_addr,
  input wire logic work_wr_en
);
  logic mode_q, kind_q, lv_q;
  logic [7:0] lines;
  always @(posedge core_clk) begin
    lv_q <= lv_in;
    if (!gen_busy) lines <= 8'h00;
    else if (lv_in && !lv_q && lines != 8'hff) lines <= lines + 8'h01;
    if (cmd_valid && csr_wr && csr_gen != 2'h0 && !gen_busy) begin
      mode_q <= single_line_mode;
      kind_q <= csr_gen != 2'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_quiet_busy: assert property (
    gen_busy && $past(gen_busy) |-> !cmd_ack) else $error("ack in run");
  a_ack_cause: assert property (
    cmd_ack |-> $past(cmd_valid) && !$past(gen_busy)) else $error("bad ack");
  a_start_ack: assert property (
    $rose(gen_busy) |-> cmd_ack && $past(csr_wr && csr_gen != 2'h0))
    else $error("bad start");
  a_valid_follow: assert property (1'b1 |=>
    line_valid_out == $past(lv_in) && data_valid_out == $past(dv_in))
    else $error("valid not passed");
  a_done_end: assert property (
    gen_done |-> gen_busy ##1 !gen_busy) else $error("run not ended");
  a_done_user: assert property (
    gen_done |-> active_user) else $error("user table idle");
  a_fall_done: assert property (
    $fell(gen_busy) |-> $past(gen_done)) else $error("end without done");
  a_line_count: assert property (
    gen_done |-> lines >= (kind_q ? 8'd128 : 8'd64)) else $error("few lines");
  a_wr_user: assert property (
    nv_wr_en |-> gen_busy && nv_addr[LW+2]) else $error("stray write");
  a_wr_area: assert property (nv_wr_en |->
    nv_addr[LW+1] == kind_q && nv_addr[LW] == mode_q) else $error("area");
  a_boot_copy: assert property (
    $rose(reset_n) |-> ##[1:8] work_wr_en) else $error("no boot copy");
endmodule
bind shc_calibration_engine shc_cal_props #(.LW(LW)) u_props (
  .core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
  .csr_wr(csr_wr), .csr_gen(csr_gen), .single_line_mode(single_line_mode),
  .cmd_ack(cmd_ack), .gen_busy(gen_busy), .gen_done(gen_done),
  .active_user(active_user), .lv_in(lv_in), .dv_in(dv_in),
  .line_valid_out(line_valid_out), .data_valid_out(data_valid_out),
  .nv_wr_en(nv_wr_en), .nv_addr(nv_addr), .work_wr_en(work_wr_en)
);
`default_nettype wire

// [sim/shc_nv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module shc_nv_model #(parameter LW = 3) (
  // Storage port of the engine.
  input wire logic core_clk,
  input wire logic nv_rd_en,
  input wire logic nv_wr_en,
  input wire logic [LW+2:0] nv_addr,
  input wire logic [15:0] nv_wr_data,
  output logic [15:0] nv_rd_data
);
  logic [15:0] mem [0:(1 << (LW + 3)) - 1];
  initial nv_rd_data = 16'h0000;
  // Data turns over after one cycle, so a late sample cannot pass.
  always @(posedge core_clk) begin
    if (nv_wr_en) mem[nv_addr] <= nv_wr_data;
    if (nv_rd_en) nv_rd_data <= mem[nv_addr];
    else nv_rd_data <= ~nv_rd_data;
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LW = 3;
  logic core_clk, reset_n, cmd_valid, csr_wr, single_line_mode;
  logic cmd_ack, gen_busy, gen_done, line_trigger_in, sensor_trigger;
  logic lv_in, dv_in, line_valid_out, data_valid_out;
  logic nv_active_user, nv_rd_en, nv_wr_en, active_user, work_wr_en;
  logic [1:0] csr_gen;
  logic [7:0] pix_in, pix_out;
  logic [15:0] nv_rd_data, nv_wr_data, work_data;
  logic [LW+2:0] nv_addr;
  logic [LW+1:0] work_addr;
  logic [31:0] seed;
  logic exp_user, ack;
  logic rst_ok;
  logic [2:0] trig_h;
  logic [7:0] pix_h;
  int fails, n_checks, cyc;
  int sum [8];
  shc_calibration_engine #(.LW(LW)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .csr_wr(csr_wr), .csr_gen(csr_gen), .single_line_mode(single_line_mode),
    .cmd_ack(cmd_ack), .gen_busy(gen_busy), .gen_done(gen_done),
    .line_trigger_in(line_trigger_in), .sensor_trigger(sensor_trigger),
    .lv_in(lv_in), .dv_in(dv_in), .pix_in(pix_in),
    .line_valid_out(line_valid_out), .data_valid_out(data_valid_out),
    .pix_out(pix_out), .nv_active_user(nv_active_user),
    .nv_rd_data(nv_rd_data), .nv_rd_en(nv_rd_en), .nv_wr_en(nv_wr_en),
    .nv_addr(nv_addr), .nv_wr_data(nv_wr_data), .active_user(active_user),
    .work_wr_en(work_wr_en), .work_addr(work_addr), .work_data(work_data)
  );
  shc_nv_model #(.LW(LW)) nv_u (
    .core_clk(core_clk), .nv_rd_en(nv_rd_en), .nv_wr_en(nv_wr_en),
    .nv_addr(nv_addr), .nv_wr_data(nv_wr_data), .nv_rd_data(nv_rd_data)
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmd(input logic wr, input logic [1:0] gen);
    @(negedge core_clk);
    cmd_valid = 1;
    csr_wr = wr;
    csr_gen = gen;
    @(negedge core_clk);
    cmd_valid = 0;
    csr_wr = 0;
    csr_gen = 0;
    ack = cmd_ack;
  endtask
  task automatic line(input bit acc, input int lo, input int span);
    logic [7:0] p;
    line_trigger_in = 1;
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      p = (i == 5) ? 8'(lo / 2 + rnd() % 8) : 8'(lo + rnd() % span);
      lv_in = 1;
      dv_in = 1;
      pix_in = p;
      line_trigger_in = 0;
      if (acc) sum[i] += p;
    end
    @(negedge core_clk);
    lv_in = 0;
    dv_in = 0;
    pix_in = 8'(rnd());
    @(negedge core_clk);
  endtask
  task automatic boot(input logic u);
    reset_n = 0;
    nv_active_user = u;
    exp_user = u;
    repeat (10) @(negedge core_clk);
    reset_n = 1;
    ack = 0;
    for (int i = 0; i < 200 && ack !== 1'b1; i++) cmd(1'b0, 2'h0);
    check(ack, 1);
  endtask
  task automatic run(input logic [1:0] gen, input logic mode);
    int n, lo, rv, c, e;
    int avg [8];
    n = (gen == 2'h1) ? 64 : 128;
    lo = (gen == 2'h1) ? 0 : 200;
    single_line_mode = mode;
    exp_user = 1;
    foreach (sum[i]) sum[i] = 0;
    lv_in = 1;
    dv_in = 1;
    cmd(1'b1, gen);
    check(ack, 1);
    check(gen_busy, 1);
    line(0, 0, 256);
    cmd(1'b1, 2'h2);
    check(ack, 0);
    for (int l = 0; l < n; l++) line(1, lo, lo ? 56 : 32);
    for (e = 0; e < 3000 && gen_done !== 1'b1; e++) @(negedge core_clk);
    check(gen_done, 1);
    check(active_user, 1);
    @(negedge core_clk);
    check(gen_busy, 0);
    rv = 0;
    foreach (avg[i]) begin
      avg[i] = sum[i] / n;
      if (avg[i] > rv) rv = avg[i];
    end
    foreach (avg[i]) begin
      c = avg[i];
      if (gen == 2'h3) c = c + nv_u.mem[32 + mode * 8 + i];
      if (c > rv) c = rv;
      if (gen == 2'h1) e = rv - c;
      else if (c * 100 < rv * 67) e = rv * 25600 / (rv * 67);
      else e = rv * 256 / c;
      c = 32 + (gen != 2'h1) * 16 + mode * 8 + i;
      check(nv_u.mem[c], e);
    end
  endtask
  always @(negedge core_clk) begin
    if (reset_n && work_wr_en === 1'b1) begin
      check(work_data, nv_u.mem[{exp_user, work_addr}]);
    end
    if (rst_ok === 1'b1) begin
      check(sensor_trigger, trig_h[2]);
      check(pix_out, pix_h);
    end
  end
  // Inputs as the design saw them, for the delayed pass-through outputs.
  always @(posedge core_clk) begin
    rst_ok <= reset_n;
    trig_h <= reset_n ? {trig_h[1:0], line_trigger_in} : 3'h0;
    pix_h <= pix_in;
  end
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      results();
    end
  end
  initial begin
    seed = 32'hb74cb4b2;
    {cmd_valid, csr_wr, csr_gen, single_line_mode} = '0;
    {line_trigger_in, lv_in, dv_in, pix_in} = '0;
    for (int i = 0; i < 64; i++) nv_u.mem[i] = 16'(rnd());
    boot(1'b0);
    cmd(1'b1, 2'h0);
    check(gen_busy, 0);
    run(2'h1, 1'b0);
    run(2'h3, 1'b0);
    run(2'h2, 1'b1);
    run(2'h1, 1'b1);
    boot(1'b1);
    results();
  end
endmodule
`default_nettype wire
